// ==== hdl/elss_src_mux.sv ====
`timescale 1ns/10ps
//------------------------------------------------------------
// Per-line source multiplexer
//------------------------------------------------------------
module elss_src_mux (
  // Select registers
  input  wire logic [31:0] sel_low_in,
  input  wire logic [31:0] sel_high_in,
  // Synchronised pins
  input  wire logic [7:0]  port_a_in,
  input  wire logic [7:0]  port_b_in,
  input  wire logic [1:0]  port_c_in,
  // Line levels
  output logic      [7:0]  line_out
);

  // A code without a source gives a quiet low, so no stray edge appears
  function automatic logic pick(input logic [1:0] code, input logic a, input logic b,
                                input logic c_ok, input logic c);
    logic r;
    r = 1'b0;
    if (code == elss_pkg::SRC_PORT_A) begin
      r = a;
    end else if (code == elss_pkg::SRC_PORT_B) begin
      r = b;
    end else if (c_ok && code == elss_pkg::SRC_PORT_C) begin
      r = c;
    end
    return r;
  endfunction

  // One pin per line, reserved codes route nothing [R10]
  always_comb begin
    line_out[0] = pick(sel_low_in[elss_pkg::LINE0_LSB +: 2], port_a_in[0], port_b_in[0], 1'b1,
                       port_c_in[0]); // [R1]
    line_out[1] = pick(sel_low_in[elss_pkg::LINE1_LSB +: 2], port_a_in[1], port_b_in[1], 1'b1,
                       port_c_in[1]); // [R2]
    line_out[2] = pick(sel_low_in[elss_pkg::LINE2_LSB +: 2], port_a_in[2], port_b_in[2], 1'b0,
                       1'b0); // [R3]
    line_out[3] = pick(sel_low_in[elss_pkg::LINE3_LSB +: 2], port_a_in[3], port_b_in[3], 1'b0,
                       1'b0); // [R4]
    line_out[4] = pick(sel_high_in[elss_pkg::LINE4_LSB +: 2], port_a_in[4], port_b_in[4], 1'b0,
                       1'b0); // [R5]
    line_out[5] = pick({1'b0, sel_high_in[elss_pkg::LINE5_LSB]}, port_a_in[5], port_b_in[5], 1'b0,
                       1'b0); // [R6]
    line_out[6] = pick(sel_high_in[elss_pkg::LINE6_LSB +: 2], port_a_in[6], port_b_in[6], 1'b0,
                       1'b0); // [R7]
    line_out[7] = pick({1'b0, sel_high_in[elss_pkg::LINE7_LSB]}, port_a_in[7], port_b_in[7], 1'b0,
                       1'b0); // [R8]
  end

endmodule

// ==== hdl/elss_sync.sv ====
`timescale 1ns/10ps
//------------------------------------------------------------
// Two-stage synchroniser for asynchronous pin levels
//------------------------------------------------------------
module elss_sync #(
  parameter int WIDTH = 18
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Pin levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } elss_sync_state_type;

  elss_sync_state_type st_q;
  elss_sync_state_type st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.sync;

endmodule

// ==== hdl/elss_top.sv ====
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
//------------------------------------------------------------
// External line source select with edge detect and pending flags
//------------------------------------------------------------
module elss_top (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  // APB slave
  input  wire elss_pkg::elss_apb_req_type apb_in,
  output elss_pkg::elss_apb_rsp_type      apb_out,
  // GPIO pins, asynchronous
  input  wire logic [7:0]                 gpio_port_a_in,
  input  wire logic [7:0]                 gpio_port_b_in,
  input  wire logic [1:0]                 gpio_port_c_in,
  // Line status
  output logic      [7:0]                 line_pending_flag_out,
  output logic                            irq_out
);

  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  typedef struct packed {
    logic [31:0] sel_low;
    logic [31:0] sel_high;
    logic [15:0] trig;
    logic [7:0]  mask;
    logic [7:0]  pending;
    logic [7:0]  line_prev;
    logic [31:0] prdata;
  } elss_state_type;

  elss_state_type st_q;
  elss_state_type st_d;

  logic [17:0] pins_sync;
  logic [7:0]  port_a_s;
  logic [7:0]  port_b_s;
  logic [1:0]  port_c_s;
  logic [7:0]  line_lvl;
  logic [7:0]  evt;
  logic [7:0]  sw_evt;
  logic [7:0]  clr;
  logic        setup;
  logic        access;
  logic        wr;

  //------------------------------------------------------------
  // Pin synchronisers and source selection
  //------------------------------------------------------------
  elss_sync #(
    .WIDTH (18)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({gpio_port_c_in, gpio_port_b_in, gpio_port_a_in}),
    .sync_out (pins_sync)
  );

  assign port_a_s = pins_sync[7:0];
  assign port_b_s = pins_sync[15:8];
  assign port_c_s = pins_sync[17:16];

  elss_src_mux u_mux (
    .sel_low_in  (st_q.sel_low),
    .sel_high_in (st_q.sel_high),
    .port_a_in   (port_a_s),
    .port_b_in   (port_b_s),
    .port_c_in   (port_c_s),
    .line_out    (line_lvl)
  );

  //------------------------------------------------------------
  // Bus decode
  //------------------------------------------------------------
  function automatic logic addr_known(input logic [11:0] a);
    return (a == elss_pkg::ADDR_TRIG_CFG) || (a == elss_pkg::ADDR_SW_TRIG) ||
           (a == elss_pkg::ADDR_PENDING) || (a == elss_pkg::ADDR_SEL_LOW) ||
           (a == elss_pkg::ADDR_SEL_HIGH) || (a == elss_pkg::ADDR_IRQ_MASK);
  endfunction

  // Zero wait states: read data is captured in the setup cycle so it comes from a flop
  assign setup  = apb_in.psel && !apb_in.penable;
  assign access = apb_in.psel && apb_in.penable;
  assign wr     = access && apb_in.pwrite && addr_known(apb_in.paddr);

  always_comb begin
    apb_out.pready  = 1'b1;
    apb_out.pslverr = access && !addr_known(apb_in.paddr);
    apb_out.prdata  = st_q.prdata;
  end

  // Write-one strobes for software trigger and pending clear
  assign sw_evt = (wr && apb_in.paddr == elss_pkg::ADDR_SW_TRIG) ? apb_in.pwdata[7:0] : 8'h00;
  assign clr    = (wr && apb_in.paddr == elss_pkg::ADDR_PENDING) ? apb_in.pwdata[7:0] : 8'h00;

  // Selected edges plus software requests
  assign evt = (line_lvl & ~st_q.line_prev & st_q.trig[7:0]) |
               (~line_lvl & st_q.line_prev & st_q.trig[elss_pkg::TRIG_FALL_LSB +: 8]) |
               sw_evt;

  //------------------------------------------------------------
  // Next state
  //------------------------------------------------------------
  always_comb begin
    st_d           = st_q;
    st_d.line_prev = line_lvl;
    // A new event beats a clear in the same cycle [R9]
    st_d.pending   = (st_q.pending & ~clr) | evt;
    if (setup) begin
      unique case (apb_in.paddr)
        elss_pkg::ADDR_TRIG_CFG: st_d.prdata = {16'h0000, st_q.trig};
        elss_pkg::ADDR_PENDING:  st_d.prdata = {24'h000000, st_q.pending};
        elss_pkg::ADDR_SEL_LOW:  st_d.prdata = st_q.sel_low;
        elss_pkg::ADDR_SEL_HIGH: st_d.prdata = st_q.sel_high;
        elss_pkg::ADDR_IRQ_MASK: st_d.prdata = {24'h000000, st_q.mask};
        default:                 st_d.prdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (apb_in.paddr)
        elss_pkg::ADDR_TRIG_CFG: st_d.trig     = apb_in.pwdata[15:0];
        elss_pkg::ADDR_SEL_LOW:  st_d.sel_low  = apb_in.pwdata & elss_pkg::SEL_LOW_WMASK;  // [R11]
        elss_pkg::ADDR_SEL_HIGH: st_d.sel_high = apb_in.pwdata & elss_pkg::SEL_HIGH_WMASK; // [R11]
        elss_pkg::ADDR_IRQ_MASK: st_d.mask     = apb_in.pwdata[7:0];
        default:                 st_d.mask     = st_q.mask;
      endcase
    end
  end

  // Select fields reset to port A [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8]
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q.sel_low   <= elss_pkg::SEL_RESET;
      st_q.sel_high  <= elss_pkg::SEL_RESET;
      st_q.trig      <= elss_pkg::TRIG_RESET;
      st_q.mask      <= elss_pkg::MASK_RESET;
      st_q.pending   <= elss_pkg::PENDING_RESET;
      st_q.line_prev <= 8'h00;
      st_q.prdata    <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  // Level interrupt, high while an unmasked pending bit stands
  assign line_pending_flag_out = st_q.pending;
  assign irq_out               = |(st_q.pending & st_q.mask);

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  a_line0_port_c: assert property (@(posedge clk_in) disable iff (rst_in) // [R1]
    st_q.sel_low[1:0] == 2'h2 |-> line_lvl[0] == port_c_s[0])
    else $error("line 0 not routed from port C");

  a_line1_reserved: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
    st_q.sel_low[9:8] == 2'h3 |-> !line_lvl[1])
    else $error("reserved code routed a pin to line 1");

  a_line2_port_b: assert property (@(posedge clk_in) disable iff (rst_in) // [R3]
    st_q.sel_low[17:16] == 2'h1 |-> line_lvl[2] == port_b_s[2])
    else $error("line 2 not routed from port B");

  a_line3_port_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R4]
    st_q.sel_low[25:24] == 2'h0 |-> line_lvl[3] == port_a_s[3])
    else $error("line 3 not routed from port A");

  a_line4_no_route: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
    st_q.sel_high[1:0] inside {2'h2, 2'h3} |-> !line_lvl[4])
    else $error("line 4 active under unrouted code");

  a_line5_port_b: assert property (@(posedge clk_in) disable iff (rst_in) // [R6]
    st_q.sel_high[8] |-> line_lvl[5] == port_b_s[5])
    else $error("line 5 not routed from port B");

  a_line6_port_b: assert property (@(posedge clk_in) disable iff (rst_in) // [R7]
    st_q.sel_high[17:16] == 2'h1 |-> line_lvl[6] == port_b_s[6])
    else $error("line 6 not routed from port B");

  a_line7_port_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R8]
    !st_q.sel_high[24] |-> line_lvl[7] == port_a_s[7])
    else $error("line 7 not routed from port A");

  a_line4_port_b: assert property (@(posedge clk_in) disable iff (rst_in) // [R5]
    st_q.sel_high[1:0] == 2'h1 |-> line_lvl[4] == port_b_s[4])
    else $error("line 4 not routed from port B");

  a_pend_rise_set: assert property (@(posedge clk_in) disable iff (rst_in) // [R9]
    line_lvl[0] && !st_q.line_prev[0] && st_q.trig[0] |=> line_pending_flag_out[0])
    else $error("rising edge on line 0 did not set pending");

  a_pend_holds: assert property (@(posedge clk_in) disable iff (rst_in) // [R9]
    st_q.pending[3] && !clr[3] |=> st_q.pending[3])
    else $error("pending flag dropped without a clear");

  a_reserved_zero: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
    wr && apb_in.paddr == elss_pkg::ADDR_SEL_HIGH |=>
      (st_q.sel_high & ~elss_pkg::SEL_HIGH_WMASK) == 32'h0000_0000 &&
      st_q.sel_high == ($past(apb_in.pwdata) & elss_pkg::SEL_HIGH_WMASK))
    else $error("reserved select bits stored");

  //------------------------------------------------------------
  // Further routing and select register checks
  //------------------------------------------------------------
  a_line0_port_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R1]
    st_q.sel_low[1:0] == 2'h0 |-> line_lvl[0] == port_a_s[0])
    else $error("line 0 not routed from port A");

  a_line0_port_b: assert property (@(posedge clk_in) disable iff (rst_in) // [R1]
    st_q.sel_low[1:0] == 2'h1 |-> line_lvl[0] == port_b_s[0])
    else $error("line 0 not routed from port B");

  a_line0_reserved: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
    st_q.sel_low[1:0] == 2'h3 |-> !line_lvl[0])
    else $error("reserved code routed a pin to line 0");

  a_line1_port_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
    st_q.sel_low[9:8] == 2'h0 |-> line_lvl[1] == port_a_s[1])
    else $error("line 1 not routed from port A");

  a_line1_port_b: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
    st_q.sel_low[9:8] == 2'h1 |-> line_lvl[1] == port_b_s[1])
    else $error("line 1 not routed from port B");

  a_line1_port_c: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
    st_q.sel_low[9:8] == 2'h2 |-> line_lvl[1] == port_c_s[1])
    else $error("line 1 not routed from port C");

  a_line2_port_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R3]
    st_q.sel_low[17:16] == 2'h0 |-> line_lvl[2] == port_a_s[2])
    else $error("line 2 not routed from port A");

  a_line2_no_route: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
    st_q.sel_low[17:16] inside {2'h2, 2'h3} |-> !line_lvl[2])
    else $error("line 2 active under unrouted code");

  a_line3_port_b: assert property (@(posedge clk_in) disable iff (rst_in) // [R4]
    st_q.sel_low[25:24] == 2'h1 |-> line_lvl[3] == port_b_s[3])
    else $error("line 3 not routed from port B");

  a_line3_no_route: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
    st_q.sel_low[25:24] inside {2'h2, 2'h3} |-> !line_lvl[3])
    else $error("line 3 active under unrouted code");

  a_line4_port_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R5]
    st_q.sel_high[1:0] == 2'h0 |-> line_lvl[4] == port_a_s[4])
    else $error("line 4 not routed from port A");

  a_line5_port_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R6]
    !st_q.sel_high[8] |-> line_lvl[5] == port_a_s[5])
    else $error("line 5 not routed from port A");

  a_line6_port_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R7]
    st_q.sel_high[17:16] == 2'h0 |-> line_lvl[6] == port_a_s[6])
    else $error("line 6 not routed from port A");

  a_line6_no_route: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
    st_q.sel_high[17:16] inside {2'h2, 2'h3} |-> !line_lvl[6])
    else $error("line 6 active under unrouted code");

  a_line7_port_b: assert property (@(posedge clk_in) disable iff (rst_in) // [R8]
    st_q.sel_high[24] |-> line_lvl[7] == port_b_s[7])
    else $error("line 7 not routed from port B");

  a_sel_low_held: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
    !(wr && apb_in.paddr == elss_pkg::ADDR_SEL_LOW) |=> $stable(st_q.sel_low))
    else $error("low select changed without a write");

  a_sel_high_held: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
    !(wr && apb_in.paddr == elss_pkg::ADDR_SEL_HIGH) |=> $stable(st_q.sel_high))
    else $error("high select changed without a write");

  a_sel_low_masked: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
    wr && apb_in.paddr == elss_pkg::ADDR_SEL_LOW |=>
      st_q.sel_low == ($past(apb_in.pwdata) & elss_pkg::SEL_LOW_WMASK))
    else $error("low select write not masked");

  //------------------------------------------------------------
  // Pending flag checks
  //------------------------------------------------------------
  // The previous level must follow the line, or edges would be missed or doubled
  a_edge_tracked: assert property (@(posedge clk_in) disable iff (rst_in) // [R9]
    1'b1 |=> st_q.line_prev == $past(line_lvl))
    else $error("edge detector lost the line level");

  a_pend_fall_set: assert property (@(posedge clk_in) disable iff (rst_in) // [R9]
    !line_lvl[0] && st_q.line_prev[0] && st_q.trig[8] |=> line_pending_flag_out[0])
    else $error("falling edge on line 0 did not set pending");

  a_pend_sw_set: assert property (@(posedge clk_in) disable iff (rst_in) // [R9]
    sw_evt != 8'h00 |=> (st_q.pending & $past(sw_evt)) == $past(sw_evt))
    else $error("software request did not set pending");

  a_pend_clear: assert property (@(posedge clk_in) disable iff (rst_in) // [R9]
    (clr & ~evt) != 8'h00 |=> (st_q.pending & $past(clr & ~evt)) == 8'h00)
    else $error("write of one did not clear pending");

  a_pend_no_spurious: assert property (@(posedge clk_in) disable iff (rst_in) // [R9]
    !st_q.pending[3] && !evt[3] |=> !st_q.pending[3])
    else $error("pending flag set without an event");

endmodule

// ==== inc/elss_pkg.sv ====
//------------------------------------------------------------
// Contract
// (R1) Line 0 field bits 1:0 of low select: 00 port A, 01 port B, 10 port C.
// (R2) Line 1 field bits 9:8 of low select: 00 port A, 01 port B, 10 port C.
// (R3) Line 2 field bits 17:16 of low select: 00 port A, 01 port B.
// (R4) Line 3 field bits 25:24 of low select: 00 port A, 01 port B.
// (R5) Line 4 field bits 1:0 of high select: 00 port A, 01 port B.
// (R6) Line 5 bit 8 of high select: 0 port A, 1 port B.
// (R7) Line 6 field bits 17:16 of high select: 0 port A, 1 port B.
// (R8) Line 7 bit 24 of high select: 0 port A, 1 port B.
// (R9) Qualifying edge or software trigger sets pending; writing one clears it.
// (R10) Each line sees one selected pin; a reserved code routes nothing.
// (R11) Reserved select bits ignore writes and read as zero.
//------------------------------------------------------------
package elss_pkg;

  //------------------------------------------------------------
  // Register map
  //------------------------------------------------------------
  localparam logic [11:0] ADDR_TRIG_CFG = 12'h000;
  localparam logic [11:0] ADDR_SW_TRIG  = 12'h010;
  localparam logic [11:0] ADDR_PENDING  = 12'h014;
  localparam logic [11:0] ADDR_SEL_LOW  = 12'h060;
  localparam logic [11:0] ADDR_SEL_HIGH = 12'h064;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h080;

  // Writable bits; everything else is reserved and reads zero
  localparam logic [31:0] SEL_LOW_WMASK  = 32'h0303_0303;
  localparam logic [31:0] SEL_HIGH_WMASK = 32'h0103_0103;

  // Reset values
  localparam logic [31:0] SEL_RESET     = 32'h0000_0000;
  localparam logic [15:0] TRIG_RESET    = 16'h0000;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [7:0]  PENDING_RESET = 8'h00;

  // Field positions
  localparam int LINE0_LSB = 0;
  localparam int LINE1_LSB = 8;
  localparam int LINE2_LSB = 16;
  localparam int LINE3_LSB = 24;
  localparam int LINE4_LSB = 0;
  localparam int LINE5_LSB = 8;
  localparam int LINE6_LSB = 16;
  localparam int LINE7_LSB = 24;
  localparam int TRIG_FALL_LSB = 8;

  // Source codes
  localparam logic [1:0] SRC_PORT_A = 2'h0;
  localparam logic [1:0] SRC_PORT_B = 2'h1;
  localparam logic [1:0] SRC_PORT_C = 2'h2;

  //------------------------------------------------------------
  // Bus carriers
  //------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } elss_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } elss_apb_rsp_type;

endpackage

// ==== tb/elss_gpio_model.sv ====
`timescale 1ns/10ps
//------------------------------------------------------------
// Pin levels of ports A, B and C as seen by the line selector
//------------------------------------------------------------
module elss_gpio_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Requested levels, {port C, port B, port A}
  input  wire logic [17:0] level_in,
  // Pins
  output logic      [7:0]  port_a_out,
  output logic      [7:0]  port_b_out,
  output logic      [1:0]  port_c_out
);
  // Pins move just after an edge and hold whole cycles, so no pulse is narrower than the synchroniser needs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {port_c_out, port_b_out, port_a_out} <= 18'h00000;
    end else begin
      {port_c_out, port_b_out, port_a_out} <= level_in;
    end
  end
endmodule

// ==== tb/ext_line_source_select_tb.sv ====
`timescale 1ns/10ps
module ext_line_source_select_tb;
  //------------------------------------------------------------
  // Signals
  //------------------------------------------------------------
  logic                       clk_in;
  logic                       rst_in;
  elss_pkg::elss_apb_req_type req;
  elss_pkg::elss_apb_rsp_type rsp;
  logic [17:0]                pins;
  logic [7:0]                 port_a;
  logic [7:0]                 port_b;
  logic [1:0]                 port_c;
  logic [7:0]                 pend;
  logic                       irq;
  logic [32:0]                expq[$];
  int                         mismatches;
  int                         checks;
  logic [31:0]                seed;

  // Free-running 25 MHz clock
  initial clk_in = 1'b0;
  always #20 clk_in = ~clk_in;

  elss_gpio_model pins_model (.clk_in(clk_in), .rst_in(rst_in), .level_in(pins),
                              .port_a_out(port_a), .port_b_out(port_b), .port_c_out(port_c));
  elss_top dut (.clk_in(clk_in), .rst_in(rst_in), .apb_in(req), .apb_out(rsp), .gpio_port_a_in(port_a),
                .gpio_port_b_in(port_b), .gpio_port_c_in(port_c), .line_pending_flag_out(pend),
                .irq_out(irq));

  //------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk_in);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      $display("BAD %0t bus answer timed out", $time);
      complete_run();
    end
  endtask

  // A read notes its expected word and error flag for the monitor
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    expq.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask

  // Monitor: every completed read is compared with the oldest note
  always @(posedge clk_in) begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
      if (expq.size() == 0) begin
        mismatches++;
        $display("BAD %0t read with no expected value", $time);
      end else begin
        chk({rsp.pslverr, rsp.prdata}, expq.pop_front());
      end
    end
  end

  // Watchdog so a hang still reaches the verdict
  initial begin
    repeat (100000) @(posedge clk_in);
    mismatches++;
    $display("BAD %0t run timed out", $time);
    complete_run();
  end

  //------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------
  initial begin
    int          e;
    int          src;
    logic [17:0] v;
    rst_in = 1'b1;
    req    = '0;
    pins   = 18'h00000;
    seed   = 32'h0000_81c9;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(elss_pkg::ADDR_SEL_LOW, elss_pkg::SEL_RESET, 1'b0);
    rd(elss_pkg::ADDR_SEL_HIGH, elss_pkg::SEL_RESET, 1'b0);
    // Four random words per select register; reserved bits must read back as zero
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      apb(1'b1, elss_pkg::ADDR_SEL_LOW, seed);
      rd(elss_pkg::ADDR_SEL_LOW, seed & elss_pkg::SEL_LOW_WMASK, 1'b0);
      seed = xs(seed);
      apb(1'b1, elss_pkg::ADDR_SEL_HIGH, seed);
      rd(elss_pkg::ADDR_SEL_HIGH, seed & elss_pkg::SEL_HIGH_WMASK, 1'b0);
    end
    rd(12'h020, 32'h0, 1'b1);
    apb(1'b1, elss_pkg::ADDR_TRIG_CFG, 32'h0000_00ff);
    apb(1'b1, elss_pkg::ADDR_IRQ_MASK, 32'h0000_00ff);
    // Every code on every line; unselected ports rise first and must stay unseen
    for (int l = 0; l < 8; l++) begin
      for (int c = 0; c < 4; c++) begin
        e = (l == 5 || l == 7) ? (c & 1) : c;
        src = (e < 2) ? e : ((e == 2 && l < 2) ? 2 : 3);
        pins <= 18'h00000;
        repeat (4) @(posedge clk_in);
        apb(1'b1, (l < 4) ? elss_pkg::ADDR_SEL_LOW : elss_pkg::ADDR_SEL_HIGH, 32'(c) << (8 * (l % 4)));
        repeat (4) @(posedge clk_in);
        apb(1'b1, elss_pkg::ADDR_PENDING, 32'h0000_00ff);
        v = 18'h00000;
        for (int p = 0; p < 3; p++) begin
          if (p != src && (p < 2 || l < 2)) v[p * 8 + l] = 1'b1;
        end
        pins <= v;
        repeat (5) @(posedge clk_in);
        rd(elss_pkg::ADDR_PENDING, 32'h0, 1'b0);
        if (src < 3) v[src * 8 + l] = 1'b1;
        pins <= v;
        repeat (5) @(posedge clk_in);
        rd(elss_pkg::ADDR_PENDING, (src < 3) ? (32'h1 << l) : 32'h0, 1'b0);
        @(negedge clk_in);
        chk({32'h0, irq}, {32'h0, 1'(src < 3)});
        chk({25'h0, pend}, (src < 3) ? (33'h1 << l) : 33'h0);
      end
    end
    // Software trigger, masking, and write-one clear
    pins <= 18'h00000;
    apb(1'b1, elss_pkg::ADDR_PENDING, 32'h0000_00ff);
    apb(1'b1, elss_pkg::ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, elss_pkg::ADDR_SW_TRIG, 32'h0000_0001);
    apb(1'b1, elss_pkg::ADDR_PENDING, 32'h0);
    rd(elss_pkg::ADDR_PENDING, 32'h0000_0001, 1'b0);
    @(negedge clk_in);
    chk({32'h0, irq}, 33'h0);
    apb(1'b1, elss_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    @(negedge clk_in);
    chk({32'h0, irq}, 33'h1);
    apb(1'b1, elss_pkg::ADDR_PENDING, 32'h0000_0001);
    @(negedge clk_in);
    chk({32'h0, irq}, 33'h0);
    rd(elss_pkg::ADDR_PENDING, 32'h0, 1'b0);
    // Falling edge on line 0 only; its rising edge must stay unseen
    apb(1'b1, elss_pkg::ADDR_SEL_LOW, 32'h0);
    apb(1'b1, elss_pkg::ADDR_TRIG_CFG, 32'h0000_0100);
    rd(elss_pkg::ADDR_TRIG_CFG, 32'h0000_0100, 1'b0);
    pins <= 18'h00001;
    repeat (5) @(posedge clk_in);
    rd(elss_pkg::ADDR_PENDING, 32'h0, 1'b0);
    pins <= 18'h00000;
    repeat (5) @(posedge clk_in);
    rd(elss_pkg::ADDR_PENDING, 32'h0000_0001, 1'b0);
    // Reset in mid-run clears a fresh pending flag and the high select
    apb(1'b1, elss_pkg::ADDR_SW_TRIG, 32'h0000_0080);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    chk({32'h0, irq}, 33'h0);
    chk({25'h0, pend}, {25'h0, elss_pkg::PENDING_RESET});
    rd(elss_pkg::ADDR_SEL_HIGH, elss_pkg::SEL_RESET, 1'b0);
    repeat (2) @(posedge clk_in);
    if (expq.size() != 0) begin
      mismatches++;
      $display("BAD %0t reads left unanswered", $time);
    end
    complete_run();
  end
endmodule
